// ===== src/rre_exec.v
// Summary of operation
// - Plain return pops stack top into the program counter; fetch resumes there.
// - Return-with-immediate restores PC and loads immediate byte into accumulator.
// - Interrupt return restores PC and sets master interrupt enable to 1.
// - Master interrupt enable clear blocks servicing of every interrupt request.
// - Pending interrupt at interrupt return is entered before resuming main code.
// - Rotate left moves bit i to i+1, old bit 7 into bit 0.
`timescale 1ns/1ps
`include "rre_map.vh"

module rre_exec (
	input  wire                    ref_clk,     // Core clock, 10 MHz
	input  wire                    rst_b,       // Synchronous reset, active low
	input  wire                    op_valid,    // Decoded operation valid, one cycle
	input  wire [`RRE_OP_W-1:0]    op_code,     // Decoded operation
	input  wire [7:0]              op_imm,      // Immediate byte of the instruction
	input  wire [`RRE_PC_W-1:0]    pc_next,     // Sequential next PC from fetch
	input  wire                    push_req,    // Call or interrupt entry push, one cycle
	input  wire [`RRE_PC_W-1:0]    push_pc,     // Return address to push
	input  wire                    emi_clr,     // Clear enable on interrupt entry
	input  wire                    emi_wr,      // Software write of the enable bit
	input  wire                    emi_wdata,   // Value for the enable write
	input  wire                    irq_pending, // Some interrupt request is pending
	input  wire [7:0]              mem_rdata,   // Addressed data memory byte
	output reg  [`RRE_PC_W-1:0]    pc_r,        // Program counter
	output reg                     pc_load_r,   // PC loaded from stack this cycle
	output reg  [7:0]              acc_r,       // Accumulator
	output reg                     master_interrupt_enable, // Global enable
	output wire                    irq_take,    // Service the pending request now
	output reg  [7:0]              mem_wdata_r, // Rotated byte to write back
	output reg                     mem_we_r,    // Write strobe for data memory
	output reg  [`RRE_LVL_W-1:0]   stk_lvl_r,   // Stack level
	output wire                    stk_empty    // Stack holds no entry
);

	//////////////////////////////////////////////////////////////////////////
	// Decode; codes outside the table, none included, select nothing
	reg  is_ret;
	reg  is_ret_im;
	reg  is_interrupt_return_op;
	reg  is_rot;
	wire any_ret;

	always @* begin
		is_ret    = 1'h0;
		is_ret_im = 1'h0;
		is_interrupt_return_op   = 1'h0;
		is_rot    = 1'h0;
		if (op_valid) begin
			case (op_code)
				`RRE_OP_RET: begin
					is_ret = 1'h1;
				end
				`RRE_OP_RET_IMM: begin
					is_ret_im = 1'h1;
				end
				`RRE_OP_INTERRUPT_RETURN_OP: begin
					is_interrupt_return_op = 1'h1;
				end
				`RRE_OP_ROTL: begin
					is_rot = 1'h1;
				end
				default: begin
					is_ret = 1'h0;
				end
			endcase
		end
	end

	// One flag for every kind of return
	assign any_ret = is_ret || is_ret_im || is_interrupt_return_op;

	// Stack storage, flip-flops indexed by level
	reg  [`RRE_PC_W-1:0]  stk_mem [0:`RRE_STACK_DEPTH-1];
	wire [`RRE_LVL_W-1:0] top_idx  = stk_lvl_r - `RRE_LVL_ONE;
	wire [`RRE_PC_W-1:0]  stk_top  = stk_mem[top_idx[2:0]];
	wire                  can_pop  = !stk_empty;
	wire                  stk_full = (stk_lvl_r == `RRE_LVL_FULL);

	// A return owns the stack for its cycle; a push that meets it is dropped
	wire                  do_pop   = any_ret && can_pop;
	wire                  do_push  = push_req && !stk_full && !any_ret;

	// Next values, one for each register
	reg  [`RRE_LVL_W-1:0] stk_lvl_nxt;
	reg  [`RRE_PC_W-1:0]  pc_nxt;
	reg                   pc_load_nxt;
	reg  [7:0]            acc_nxt;
	reg                   emi_nxt;
	reg  [7:0]            mem_wdata_nxt;
	reg                   mem_we_nxt;

	wire [7:0] rot_out;

	// Empty is read straight from the level, no extra flop
	assign stk_empty = (stk_lvl_r == `RRE_LVL_EMPTY);

	//////////////////////////////////////////////////////////////////////////
	// Rotate datapath
	rre_rotate u_rot (
		.din  (mem_rdata),
		.dout (rot_out)
	);

	//////////////////////////////////////////////////////////////////////////
	// global gate
	// pending entered first
	// Take is held off during any return and the enable it sets is seen the next cycle, so a pending
	// request is taken straight after the restore, before any main code runs.
	assign irq_take = irq_pending && master_interrupt_enable && !any_ret;

	//////////////////////////////////////////////////////////////////////////
	// Stack level next value: pop on any return, push on entry
	// A return on an empty stack leaves the level at zero rather than wrapping
	always @* begin
		stk_lvl_nxt = stk_lvl_r;
		if (do_pop) begin
			stk_lvl_nxt = stk_lvl_r - `RRE_LVL_ONE;
		end else if (do_push) begin
			stk_lvl_nxt = stk_lvl_r + `RRE_LVL_ONE;
		end
	end

	// Level register; the pushed word lands at the old level
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			stk_lvl_r <= `RRE_LVL_RST;
		end else begin
			stk_lvl_r <= stk_lvl_nxt;
			if (do_push) begin
				stk_mem[stk_lvl_r[2:0]] <= push_pc;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Program counter next value
	// A return always loads, even on an empty stack, where the word is undefined
	always @* begin
		pc_nxt      = pc_next;
		pc_load_nxt = 1'h0;
		if (any_ret) begin
			pc_nxt      = stk_top;
			pc_load_nxt = 1'h1;
		end
	end

	// Program counter registers
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			pc_r      <= `RRE_PC_RST;
			pc_load_r <= 1'h0;
		end else begin
			pc_r      <= pc_nxt;
			pc_load_r <= pc_load_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Accumulator next value; only the return-with-immediate writes it here
	always @* begin
		acc_nxt = acc_r;
		if (is_ret_im) begin
			acc_nxt = op_imm;
		end
	end

	// Accumulator register
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			acc_r <= `RRE_ACC_RST;
		end else begin
			acc_r <= acc_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Master interrupt enable next value
	// Priority is return set, then entry clear, then software write; the set
	// wins so a return that meets an entry still reopens the gate
	always @* begin
		emi_nxt = master_interrupt_enable;
		if (is_interrupt_return_op) begin
			emi_nxt = `RRE_EMI_SET;
		end else if (emi_clr) begin
			emi_nxt = `RRE_EMI_CLR;
		end else if (emi_wr) begin
			emi_nxt = emi_wdata;
		end
	end

	// Enable register
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			master_interrupt_enable <= `RRE_EMI_RST;
		end else begin
			master_interrupt_enable <= emi_nxt;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Write-back next values; the strobe lasts one cycle per rotate
	always @* begin
		mem_we_nxt    = is_rot;
		mem_wdata_nxt = mem_wdata_r;
		if (is_rot) begin
			mem_wdata_nxt = rot_out;
		end
	end

	// Write-back registers; the data holds its last value between strobes
	always @(posedge ref_clk) begin
		if (!rst_b) begin
			mem_wdata_r <= `RRE_WDATA_RST;
			mem_we_r    <= 1'h0;
		end else begin
			mem_wdata_r <= mem_wdata_nxt;
			mem_we_r    <= mem_we_nxt;
		end
	end

endmodule

// ===== src/rre_map.vh
`ifndef RRE_MAP_VH
`define RRE_MAP_VH

// Operation codes presented by the instruction decoder
`define RRE_OP_W          3
`define RRE_OP_NONE       3'h0
`define RRE_OP_RET        3'h1
`define RRE_OP_RET_IMM    3'h2
`define RRE_OP_INTERRUPT_RETURN_OP       3'h3
`define RRE_OP_ROTL       3'h4

// Widths
`define RRE_PC_W          13
`define RRE_DATA_W        8
`define RRE_LVL_W         4
`define RRE_STACK_DEPTH   8

// Reset values
`define RRE_PC_RST        13'h0000
`define RRE_ACC_RST       8'h00
`define RRE_WDATA_RST     8'h00
`define RRE_EMI_RST       1'h0
`define RRE_EMI_SET       1'h1
`define RRE_EMI_CLR       1'h0

// Stack level values
`define RRE_LVL_RST       4'h0
`define RRE_LVL_EMPTY     4'h0
`define RRE_LVL_ONE       4'h1
`define RRE_LVL_FULL      4'h8

// Bit positions for the rotate
`define RRE_MSB           7
`define RRE_LSB           0

`endif

// ===== src/rre_rotate.v
`timescale 1ns/1ps
`include "rre_map.vh"

//////////////////////////////////////////////////////////////////////////////
// Byte rotate left, bit 7 wraps into bit 0
module rre_rotate (
	input  wire [7:0] din,    // Byte read from data memory
	output wire [7:0] dout    // Rotated byte
);

	genvar i;

	generate
		for (i = 0; i < `RRE_MSB; i = i + 1) begin : g_shift
			assign dout[i+1] = din[i];
		end
	endgenerate

	assign dout[`RRE_LSB] = din[`RRE_MSB];

endmodule

// ===== tb/rre_exec_chk.sv
`timescale 1ns/1ps
module rre_chk (
	input wire       ref_clk,     // Clock
	input wire       rst_b,       // Reset
	input wire       op_valid,    // Op strobe
	input wire [2:0] op_code,     // Op
	input wire [7:0] op_imm,      // Imm
	input wire       irq_pending, // Pending
	input wire [7:0] mem_rdata,   // Byte in
	input wire       pc_load_r,   // PC load
	input wire [7:0] acc_r,       // Acc
	input wire       master_interrupt_enable, // Gate
	input wire       irq_take,    // Take
	input wire [7:0] mem_wdata_r, // Byte out
	input wire       mem_we_r,    // Strobe
	input wire [3:0] stk_lvl_r,   // Level
	input wire       stk_empty    // Empty
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Any return with an entry to pop
	wire rt = op_valid && op_code > 3'h0 && op_code < 3'h4 && !stk_empty;
	wire ri = rt && op_code == 3'h3;
	ret_load_a: assert property (rt |=> pc_load_r) else $error("no PC load");
	imm_acc_a: assert property (rt && op_code == 3'h2 |=> acc_r == $past(op_imm))
		else $error("acc not loaded");
	interrupt_return_op_emi_a: assert property (ri |=> master_interrupt_enable)
		else $error("gate not reopened");
	irq_gate_a: assert property (!master_interrupt_enable |-> !irq_take)
		else $error("take while gate closed");
	pend_take_a: assert property (ri ##1 (irq_pending && !op_valid) |-> irq_take)
		else $error("pending not taken");
	rot_data_a: assert property (op_valid && op_code == 3'h4 |=> mem_we_r &&
		mem_wdata_r == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}) else $error("rot");
	lvl_pop_a: assert property (rt |=> stk_lvl_r == $past(stk_lvl_r) - 4'h1)
		else $error("level");
	cover property (ri ##1 irq_take);
	cover property (op_valid && op_code == 3'h4);
	cover property (rt && op_code == 3'h2);
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	reg ref_clk = 0, rst_b = 0, op_valid = 0, push_req = 0, irq_pending = 0;
	reg emi_clr = 0, emi_wr = 0, emi_wdata = 0;
	reg [2:0] op_code = 0;
	reg [7:0] op_imm = 0, mem_rdata = 0;
	reg [12:0] pc_next = 13'h0100, push_pc = 0;
	wire [12:0] pc_r;
	wire [7:0] acc_r, mem_wdata_r;
	wire [3:0] stk_lvl_r;
	wire pc_load_r, master_interrupt_enable, irq_take, mem_we_r, stk_empty;
	integer failures = 0, checked = 0, cyc = 0;
	always #50 ref_clk = ~ref_clk;
	rre_exec i_rre_exec (.ref_clk, .rst_b, .op_valid, .op_code, .op_imm, .pc_next,
		.push_req, .push_pc, .emi_clr, .emi_wr, .emi_wdata, .irq_pending, .mem_rdata,
		.pc_r, .pc_load_r, .acc_r, .master_interrupt_enable, .irq_take, .mem_wdata_r,
		.mem_we_r, .stk_lvl_r, .stk_empty);
	task close_out;
		if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input [63:0] n, input [12:0] e, input [12:0] g);
		begin
			checked = checked + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("FAIL %0s exp %h got %h", n, e, g);
			end
		end
	endtask
	// One op or push, held for one edge; imm reuses the low address byte
	task step(input [2:0] c, input p, input [12:0] a);
		begin
			@(posedge ref_clk);
			op_valid <= c != 3'h0;
			op_code <= c;
			op_imm <= a[7:0];
			push_req <= p;
			push_pc <= a;
			@(posedge ref_clk);
			op_valid <= 0;
			push_req <= 0;
			#1;
		end
	endtask
	task t_ret;
		begin
			step(3'h0, 1'h1, 13'h0AAA);
			step(3'h0, 1'h1, 13'h1555);
			step(3'h1, 1'h0, 13'h0000);
			chk("pc", 13'h1555, pc_r);
			chk("load", 13'h0001, pc_load_r);
			chk("lvl", 13'h0001, stk_lvl_r);
			step(3'h2, 1'h0, 13'h005A);
			chk("pc", 13'h0AAA, pc_r);
			chk("acc", 13'h005A, acc_r);
			chk("empty", 13'h0001, stk_empty);
		end
	endtask
	task t_interrupt_return_op;
		begin
			@(posedge ref_clk);
			irq_pending <= 1'h1;
			step(3'h0, 1'h1, 13'h0C3C);
			chk("take", 13'h0000, irq_take);
			step(3'h3, 1'h0, 13'h0000);
			chk("pc", 13'h0C3C, pc_r);
			chk("emi", 13'h0001, master_interrupt_enable);
			chk("take", 13'h0001, irq_take);
			chk("lvl", 13'h0000, stk_lvl_r);
		end
	endtask
	task t_rot;
		begin
			@(posedge ref_clk);
			mem_rdata <= 8'hA5;
			step(3'h4, 1'h0, 13'h0000);
			chk("rot", 13'h004B, mem_wdata_r);
			chk("we", 13'h0001, mem_we_r);
		end
	endtask
	// Gate clear, software write, then a return that meets an entry clear
	task t_gate;
		begin
			@(posedge ref_clk);
			emi_clr <= 1'h1;
			@(posedge ref_clk);
			emi_clr <= 1'h0;
			#1;
			chk("emi", 13'h0000, master_interrupt_enable);
			chk("take", 13'h0000, irq_take);
			@(posedge ref_clk);
			emi_wr <= 1'h1;
			emi_wdata <= 1'h1;
			@(posedge ref_clk);
			emi_wr <= 1'h0;
			#1;
			chk("take", 13'h0001, irq_take);
			step(3'h0, 1'h1, 13'h0123);
			@(posedge ref_clk);
			op_valid <= 1'h1;
			op_code <= 3'h3;
			emi_clr <= 1'h1;
			@(posedge ref_clk);
			op_valid <= 1'h0;
			emi_clr <= 1'h0;
			#1;
			chk("pc", 13'h0123, pc_r);
			chk("emi", 13'h0001, master_interrupt_enable);
			chk("lvl", 13'h0000, stk_lvl_r);
		end
	endtask
	// Hang guard, far above the few dozen cycles used
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 500) begin
			failures = failures + 1;
			close_out;
		end
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		rst_b <= 1;
		t_ret;
		t_interrupt_return_op;
		t_rot;
		t_gate;
		close_out;
	end
endmodule
bind rre_exec rre_chk i_rre_chk (.ref_clk, .rst_b, .op_valid, .op_code, .op_imm,
	.irq_pending, .mem_rdata, .pc_load_r, .acc_r, .master_interrupt_enable, .irq_take,
	.mem_wdata_r, .mem_we_r, .stk_lvl_r, .stk_empty);
